// file: core/iala_pkg.sv
// Package for the indexed address and lane alignment datapath.
// Assumes a Wishbone classic slave with a byte address and 32-bit data.
package iala_pkg;

   // Register byte offsets on the Wishbone bus.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_REF = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_EA = 8'h0c;
   localparam logic [7:0] OFS_RESULT = 8'h10;
   localparam logic [7:0] OFS_ADDEND = 8'h14;
   localparam logic [7:0] OFS_SHIFT = 8'h18;
   localparam logic [7:0] OFS_OPERAND = 8'h1c;
   localparam logic [7:0] PRIV_BASE = 8'h40;
   localparam logic [7:0] MEM_BASE = 8'h80;

   // Depths of the private register block and the core memory window.
   localparam int PRIV_DEPTH = 8;
   localparam int MEM_DEPTH = 16;

   // Control word layout: bit 0 starts, the struct sits above it.
   localparam int CTRL_GO_BIT = 0;
   localparam int CTRL_LSB = 1;
   localparam int CTRL_W = 13;

   // Lane shift step and the counter value for halfword 0.
   localparam int LANE_STEP = 8;
   localparam logic [1:0] CNT_HALF0 = 2'h2;
   localparam logic [1:0] CNT_ZERO = 2'h0;

   // Sum bus bits forced by padding (bit 0 is the most significant).
   localparam logic [31:0] PAD_MASK_HALF = 32'hffff0000;
   localparam logic [31:0] PAD_MASK_BYTE = 32'hffffff00;
   localparam logic [31:0] PAD_MASK_IMM = 32'hfff00000;

   // Sign bit positions used to pick the padding value.
   localparam int IMM_SIGN_BIT = 19;
   localparam int HALF0_SIGN_BIT = 31;
   localparam int HALF1_SIGN_BIT = 15;

   // Reset values.
   localparam logic [31:0] WORD_RST = 32'h00000000;
   localparam logic [6:0] SHIFT_RST = 7'h00;

   typedef enum logic [2:0] {
      SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DOUBLE, SZ_SHIFT, SZ_IMMED
   } iala_size_e;

   typedef enum logic [1:0] {
      KD_LOAD, KD_STORE, KD_MODTEST
   } iala_kind_e;

   typedef enum logic [2:0] {
      PH_IDLE, PH_PREP_PHASE_ONE, PH_PREP_PHASE_TWO, PH_PREP_PHASE_THREE, PH_PREP_PHASE_FOUR, PH_EXEC, PH_DONE
   } iala_phase_e;

   // Instruction description written by software.
   typedef struct packed {
      logic [2:0] src_reg;
      logic load_abs;
      logic float_op;
      iala_kind_e kind;
      iala_size_e size;
      logic [2:0] index_sel;
   } iala_ctrl_s;

   // Status word read back by software.
   typedef struct packed {
      logic pad_zeros;
      logic pad_ones;
      logic lsb_inhibit;
      logic odd_word;
      logic lane_lo;
      logic lane_hi;
      logic [1:0] count;
      iala_phase_e phase;
      logic done;
      logic busy;
   } iala_status_s;

   localparam iala_ctrl_s CTRL_RST = '0;

endpackage

// file: core/iala_core.sv
// Preparation phase datapath: index add, lane alignment, byte counter and
// sign padding. Assumes a Wishbone classic master on clk_i and that the
// private register block and core memory window are loaded by software.
//
// Overview of operation
// RQ1 - Only registers 1..7 index; select value 0 means no indexing.
// RQ2 - Nonzero select moves the index register into the addend register.
// RQ3 - Lane comes from low index bits; no indexing selects lane 0.
// RQ4 - Word operands use the index value unshifted.
// RQ5 - Byte: addend shifts right two; dropped bits go to lane flip-flops.
// RQ6 - Third phase loads counter from lanes; fourth phase shifts by counter.
// RQ7 - Halfword: addend shifts right one; dropped bit to first lane flop.
// RQ8 - Halfword loads shift operand right; stores shift addend left.
// RQ9 - Doubleword: addend shifts left one, lsb cleared, address lsb ignored.
// RQ10 - Combined first/second step inhibits sum lsb and sets odd-word select.
// RQ11 - Odd-word select set for doublewords except floating and load-absolute.
// RQ12 - Shift instructions use index to modify shift count and direction.
// RQ13 - Byte counter loads 11, 10, 01, 00 for bytes 0..3.
// RQ14 - Counter decrements each fourth-phase pass, repeating until zero.
// RQ15 - Halfword counter stays zero for halfword 1, loads 10 for halfword 0.
// RQ16 - Stores and modify-and-test shift addend left with same encoding.
// RQ17 - Modify-and-test returns to fourth phase after an execution phase.
// RQ18 - Third phase sets pad-ones or pad-zeros; load byte zero-fills.
// RQ19 - Pad-zeros forces sum bits 0..7 to zero, pad-ones forces ones.
// RQ20 - Bits 8..15 padded likewise; immediates force only bits 8..11.
// RQ21 - Effective address goes to program address; operand read in third.
// RQ22 - Counter, lane flops and pad flags clear at each preparation start.
//
// The register addresses and register access over Wishbone were chosen for this implementation.
`timescale 1ns/100ps
module iala_core (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [31:0] prog_addr_o,
   output logic odd_word_sel_o,
   output logic busy_o
);

   iala_pkg::iala_ctrl_s ctrl;
   iala_pkg::iala_phase_e phase;
   iala_pkg::iala_status_s status;
   logic [31:0] ref_addr;
   logic [31:0] addend;
   logic [31:0] operand;
   logic [31:0] sum_bus;
   logic [6:0] shift_count;
   logic shift_left;
   logic shift_count_hi;
   logic shift_count_lo;
   logic lane_sel_hi;
   logic lane_sel_lo;
   logic sum_lsb_inhibit;
   logic pad_ones_flag;
   logic pad_zeros_flag;
   logic done;
   logic mt_second;
   logic [31:0] priv_reg [0:iala_pkg::PRIV_DEPTH-1];
   logic [31:0] core_mem [0:iala_pkg::MEM_DEPTH-1];

   logic bus_req;
   logic bus_wr;
   logic go;
   logic [31:0] next_aligned;
   logic [31:0] ref_adj;
   logic [31:0] ea_sum;
   logic [31:0] mem_word;
   logic [31:0] pad_mask;
   logic [31:0] padded;
   logic [6:0] shift_sum;
   logic [1:0] lane_count;
   logic [1:0] count;
   logic [31:0] rd_data;

   // Byte-lane merge for Wishbone writes.
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wdat,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = wdat[i*8 +: 8];
         end
      end
      return res;
   endfunction

   assign count = {shift_count_hi, shift_count_lo};
   // The ack term keeps a held request from acting twice.
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr = bus_req && wb_we_i;
   // Start is refused while a preparation sequence is running.
   assign go = bus_wr && (wb_adr_i == iala_pkg::OFS_CTRL) && wb_sel_i[0] &&
               wb_dat_i[iala_pkg::CTRL_GO_BIT] && (phase == iala_pkg::PH_IDLE);
   assign mem_word = core_mem[prog_addr_o[3:0]];

   // Displacement alignment per operand size, bit 31 being the lsb.
   always_comb begin
      next_aligned = addend; // RQ4
      ref_adj = ref_addr;
      case (ctrl.size)
         iala_pkg::SZ_BYTE: begin
            next_aligned = {2'b00, addend[31:2]}; // RQ5
         end
         iala_pkg::SZ_HALF: begin
            next_aligned = {1'b0, addend[31:1]}; // RQ7
         end
         iala_pkg::SZ_DOUBLE: begin
            next_aligned = {addend[30:0], 1'b0}; // RQ9
            ref_adj = {ref_addr[31:1], 1'b0}; // RQ9
         end
         default: begin
            next_aligned = addend;
         end
      endcase
      ea_sum = next_aligned + ref_adj;
   end

   // Shift instructions add the index to the count field instead.
   assign shift_sum = ref_addr[6:0] + addend[6:0]; // RQ12

   // Counter value from the captured lane number.
   always_comb begin
      case (ctrl.size)
         iala_pkg::SZ_BYTE: begin
            lane_count = ~{lane_sel_hi, lane_sel_lo}; // RQ13
         end
         iala_pkg::SZ_HALF: begin
            lane_count = lane_sel_hi ? iala_pkg::CNT_ZERO
                                     : iala_pkg::CNT_HALF0; // RQ15
         end
         default: begin
            lane_count = iala_pkg::CNT_ZERO;
         end
      endcase
   end

   // Padding forces upper sum bits regardless of the operand contents.
   always_comb begin
      case (ctrl.size)
         iala_pkg::SZ_IMMED: pad_mask = iala_pkg::PAD_MASK_IMM; // RQ20
         iala_pkg::SZ_BYTE: pad_mask = iala_pkg::PAD_MASK_BYTE; // RQ18
         default: pad_mask = iala_pkg::PAD_MASK_HALF; // RQ20
      endcase
      padded = operand;
      if (pad_zeros_flag) begin
         padded = operand & ~pad_mask; // RQ19
      end else if (pad_ones_flag) begin
         padded = operand | pad_mask; // RQ19
      end
   end

   // Wishbone answer: one wait state, ack drops the cycle after it rose.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   // Read data is registered with the ack; unmapped addresses read zero.
   always_comb begin
      rd_data = iala_pkg::WORD_RST;
      if (wb_adr_i >= iala_pkg::MEM_BASE &&
          wb_adr_i < iala_pkg::MEM_BASE + 8'(4 * iala_pkg::MEM_DEPTH)) begin
         rd_data = core_mem[wb_adr_i[5:2]];
      end else if (wb_adr_i >= iala_pkg::PRIV_BASE &&
          wb_adr_i < iala_pkg::PRIV_BASE + 8'(4 * iala_pkg::PRIV_DEPTH)) begin
         rd_data = priv_reg[wb_adr_i[4:2]];
      end else begin
         case (wb_adr_i)
            iala_pkg::OFS_CTRL: rd_data = {18'h0, ctrl, 1'b0};
            iala_pkg::OFS_REF: rd_data = ref_addr;
            iala_pkg::OFS_STATUS: rd_data = {19'h0, status};
            iala_pkg::OFS_EA: rd_data = prog_addr_o;
            iala_pkg::OFS_RESULT: rd_data = sum_bus;
            iala_pkg::OFS_ADDEND: rd_data = addend;
            iala_pkg::OFS_SHIFT: rd_data = {24'h0, shift_left, shift_count};
            iala_pkg::OFS_OPERAND: rd_data = operand;
            default: rd_data = iala_pkg::WORD_RST;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= iala_pkg::WORD_RST;
      end else if (bus_req && !wb_we_i) begin
         wb_dat_o <= rd_data;
      end
   end

   always_comb begin
      status.pad_zeros = pad_zeros_flag;
      status.pad_ones = pad_ones_flag;
      status.lsb_inhibit = sum_lsb_inhibit;
      status.odd_word = odd_word_sel_o;
      status.lane_lo = lane_sel_lo;
      status.lane_hi = lane_sel_hi;
      status.count = count;
      status.phase = phase;
      status.done = done;
      status.busy = busy_o;
   end

   // Control and reference words; a running sequence keeps its copy.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= iala_pkg::CTRL_RST;
         ref_addr <= iala_pkg::WORD_RST;
      end else if (bus_wr && phase == iala_pkg::PH_IDLE) begin
         if (wb_adr_i == iala_pkg::OFS_CTRL) begin
            ctrl <= iala_pkg::iala_ctrl_s'(merge({18'h0, ctrl, 1'b0},
                       wb_dat_i, wb_sel_i) >> iala_pkg::CTRL_LSB);
         end
         if (wb_adr_i == iala_pkg::OFS_REF) begin
            ref_addr <= merge(ref_addr, wb_dat_i, wb_sel_i);
         end
      end
   end

   // Private register block and core memory, written only by software.
   always_ff @(posedge clk_i) begin
      if (bus_wr && wb_adr_i >= iala_pkg::PRIV_BASE &&
          wb_adr_i < iala_pkg::PRIV_BASE + 8'(4 * iala_pkg::PRIV_DEPTH)) begin
         priv_reg[wb_adr_i[4:2]] <= merge(priv_reg[wb_adr_i[4:2]],
                                          wb_dat_i, wb_sel_i);
      end
   end

   always_ff @(posedge clk_i) begin
      if (bus_wr && wb_adr_i >= iala_pkg::MEM_BASE &&
          wb_adr_i < iala_pkg::MEM_BASE + 8'(4 * iala_pkg::MEM_DEPTH)) begin
         core_mem[wb_adr_i[5:2]] <= merge(core_mem[wb_adr_i[5:2]],
                                          wb_dat_i, wb_sel_i);
      end
   end

   // Phase sequencer; the fourth phase repeats until the counter is zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase <= iala_pkg::PH_IDLE;
         mt_second <= 1'b0;
         busy_o <= 1'b0;
         done <= 1'b0;
      end else begin
         case (phase)
            iala_pkg::PH_IDLE: begin
               if (go) begin
                  phase <= iala_pkg::PH_PREP_PHASE_ONE;
                  busy_o <= 1'b1;
                  done <= 1'b0;
                  mt_second <= 1'b0;
               end
            end
            iala_pkg::PH_PREP_PHASE_ONE: phase <= iala_pkg::PH_PREP_PHASE_TWO;
            iala_pkg::PH_PREP_PHASE_TWO: phase <= iala_pkg::PH_PREP_PHASE_THREE;
            iala_pkg::PH_PREP_PHASE_THREE: phase <= iala_pkg::PH_PREP_PHASE_FOUR;
            iala_pkg::PH_PREP_PHASE_FOUR: begin
               if (count == iala_pkg::CNT_ZERO) begin // RQ14
                  if (ctrl.kind == iala_pkg::KD_MODTEST && !mt_second) begin
                     phase <= iala_pkg::PH_EXEC;
                  end else begin
                     phase <= iala_pkg::PH_DONE;
                  end
               end
            end
            iala_pkg::PH_EXEC: begin
               phase <= iala_pkg::PH_PREP_PHASE_FOUR; // RQ17
               mt_second <= 1'b1;
            end
            iala_pkg::PH_DONE: begin
               phase <= iala_pkg::PH_IDLE;
               busy_o <= 1'b0;
               done <= 1'b1;
            end
            default: phase <= iala_pkg::PH_IDLE;
         endcase
      end
   end

   // Addend register: index load, alignment, store data and left shifts.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addend <= iala_pkg::WORD_RST;
      end else begin
         case (phase)
            iala_pkg::PH_PREP_PHASE_ONE: begin
               // Register 0 never indexes, so select 0 loads a zero.
               if (ctrl.index_sel != 3'h0) begin // RQ1
                  addend <= priv_reg[ctrl.index_sel]; // RQ2
               end else begin
                  addend <= iala_pkg::WORD_RST; // RQ1
               end
            end
            iala_pkg::PH_PREP_PHASE_TWO: begin
               if (ctrl.size != iala_pkg::SZ_SHIFT) begin
                  addend <= next_aligned;
               end
            end
            iala_pkg::PH_PREP_PHASE_THREE: begin
               if (ctrl.kind == iala_pkg::KD_STORE) begin
                  addend <= priv_reg[ctrl.src_reg];
               end
            end
            iala_pkg::PH_PREP_PHASE_FOUR: begin
               if (count != iala_pkg::CNT_ZERO &&
                   (ctrl.kind == iala_pkg::KD_STORE || mt_second)) begin
                  addend <= addend << iala_pkg::LANE_STEP; // RQ8 RQ16
               end
            end
            iala_pkg::PH_EXEC: begin
               // Stand-in modify step: increment the aligned operand.
               addend <= operand + 32'h00000001;
            end
            default: addend <= addend;
         endcase
      end
   end

   // Operand register: reference address, memory read and right shifts.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         operand <= iala_pkg::WORD_RST;
      end else begin
         case (phase)
            iala_pkg::PH_PREP_PHASE_ONE: operand <= ref_addr;
            iala_pkg::PH_PREP_PHASE_THREE: begin
               if (ctrl.size != iala_pkg::SZ_IMMED &&
                   ctrl.size != iala_pkg::SZ_SHIFT) begin
                  operand <= mem_word; // RQ21
               end
            end
            iala_pkg::PH_PREP_PHASE_FOUR: begin
               if (count != iala_pkg::CNT_ZERO &&
                   ctrl.kind != iala_pkg::KD_STORE && !mt_second) begin
                  operand <= operand >> iala_pkg::LANE_STEP; // RQ8 RQ6
               end
            end
            default: operand <= operand;
         endcase
      end
   end

   // Lane flops and byte counter.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lane_sel_hi <= 1'b0;
         lane_sel_lo <= 1'b0;
         shift_count_hi <= 1'b0;
         shift_count_lo <= 1'b0;
      end else begin
         case (phase)
            iala_pkg::PH_PREP_PHASE_ONE: begin
               lane_sel_hi <= 1'b0; // RQ22
               lane_sel_lo <= 1'b0; // RQ22
               {shift_count_hi, shift_count_lo} <= iala_pkg::CNT_ZERO; // RQ22
            end
            iala_pkg::PH_PREP_PHASE_TWO: begin
               // Low addend bits are doc bits 30 and 31 of the index.
               if (ctrl.size == iala_pkg::SZ_BYTE) begin
                  lane_sel_hi <= addend[1]; // RQ5 RQ3
                  lane_sel_lo <= addend[0]; // RQ5 RQ3
               end else if (ctrl.size == iala_pkg::SZ_HALF) begin
                  lane_sel_hi <= addend[0]; // RQ7 RQ3
               end
            end
            iala_pkg::PH_PREP_PHASE_THREE, iala_pkg::PH_EXEC: begin
               {shift_count_hi, shift_count_lo} <= lane_count; // RQ6
            end
            iala_pkg::PH_PREP_PHASE_FOUR: begin
               if (count != iala_pkg::CNT_ZERO) begin
                  {shift_count_hi, shift_count_lo} <= count - 2'h1; // RQ14
               end
            end
            default: shift_count_hi <= shift_count_hi;
         endcase
      end
   end

   // Padding flags chosen when the operand arrives.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pad_ones_flag <= 1'b0;
         pad_zeros_flag <= 1'b0;
      end else if (phase == iala_pkg::PH_PREP_PHASE_ONE) begin
         pad_ones_flag <= 1'b0; // RQ22
         pad_zeros_flag <= 1'b0; // RQ22
      end else if (phase == iala_pkg::PH_PREP_PHASE_THREE) begin
         if (ctrl.size == iala_pkg::SZ_IMMED) begin
            pad_ones_flag <= ref_addr[iala_pkg::IMM_SIGN_BIT]; // RQ18
            pad_zeros_flag <= !ref_addr[iala_pkg::IMM_SIGN_BIT]; // RQ18
         end else if (ctrl.size == iala_pkg::SZ_BYTE &&
                      ctrl.kind == iala_pkg::KD_LOAD) begin
            pad_zeros_flag <= 1'b1; // RQ18
         end else if (ctrl.size == iala_pkg::SZ_HALF &&
                      ctrl.kind != iala_pkg::KD_STORE) begin
            // Sign of the addressed halfword before it is moved down.
            if (lane_sel_hi) begin
               pad_ones_flag <= mem_word[iala_pkg::HALF1_SIGN_BIT]; // RQ18
               pad_zeros_flag <= !mem_word[iala_pkg::HALF1_SIGN_BIT];
            end else begin
               pad_ones_flag <= mem_word[iala_pkg::HALF0_SIGN_BIT]; // RQ18
               pad_zeros_flag <= !mem_word[iala_pkg::HALF0_SIGN_BIT];
            end
         end
      end
   end

   // Effective address, doubleword odd-word select and lsb inhibit.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prog_addr_o <= iala_pkg::WORD_RST;
         odd_word_sel_o <= 1'b0;
         sum_lsb_inhibit <= 1'b0;
      end else if (phase == iala_pkg::PH_PREP_PHASE_ONE) begin
         odd_word_sel_o <= 1'b0;
         sum_lsb_inhibit <= 1'b0;
      end else if (phase == iala_pkg::PH_PREP_PHASE_TWO &&
                   ctrl.size != iala_pkg::SZ_SHIFT &&
                   ctrl.size != iala_pkg::SZ_IMMED) begin
         if (ctrl.size == iala_pkg::SZ_DOUBLE) begin
            prog_addr_o <= {ea_sum[31:1], 1'b0}; // RQ10 RQ21
            sum_lsb_inhibit <= 1'b1; // RQ10
            odd_word_sel_o <= !ctrl.float_op && !ctrl.load_abs; // RQ11
         end else begin
            prog_addr_o <= ea_sum; // RQ21
         end
      end
   end

   // Shift count and direction for shift instructions.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shift_count <= iala_pkg::SHIFT_RST;
         shift_left <= 1'b0;
      end else if (phase == iala_pkg::PH_PREP_PHASE_TWO &&
                   ctrl.size == iala_pkg::SZ_SHIFT) begin
         shift_count <= shift_sum; // RQ12
         shift_left <= !shift_sum[6]; // RQ12
      end
   end

   // Sum bus result: loads present the padded operand, stores and modify-and-test the addend.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sum_bus <= iala_pkg::WORD_RST;
      end else if (phase == iala_pkg::PH_DONE) begin
         if (ctrl.kind == iala_pkg::KD_LOAD) begin
            sum_bus <= padded; // RQ19 RQ20
         end else begin
            sum_bus <= addend; // RQ16
         end
      end
   end

endmodule

// file: test/iala_core_sva.sv
// Checker for the indexed address datapath, bound to its top module.
// Assumes a classic Wishbone master and one clock domain.
`timescale 1ns/100ps
module iala_core_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic [31:0] prog_addr_o,
   input wire logic odd_word_sel_o,
   input wire logic busy_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // A request taken at this edge, and a start command among them.
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_go;
      s_take ##0 wb_we_i && wb_adr_i == iala_pkg::OFS_CTRL &&
         wb_dat_i[0] && wb_sel_i[0] && !busy_o;
   endsequence
   a_ack_answer: assert property (s_take |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_unasked: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_go_busy: assert property (s_go |=> busy_o)
      else $error("start did not raise busy");
   a_busy_min: assert property ($rose(busy_o) |-> busy_o[*5])
      else $error("preparation shorter than five phases");
   a_busy_max: assert property ($rose(busy_o) |-> ##[1:14] !busy_o)
      else $error("preparation did not end");
   a_odd_clear: assert property (s_go |-> ##2 !odd_word_sel_o)
      else $error("odd word select not cleared");
   a_odd_busy: assert property ($rose(odd_word_sel_o) |-> busy_o)
      else $error("odd word select set while idle");
   a_ea_idle: assert property (!busy_o && !$past(busy_o) |->
      $stable(prog_addr_o))
      else $error("address moved while idle");
endmodule
bind iala_core iala_core_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .prog_addr_o(prog_addr_o),
   .odd_word_sel_o(odd_word_sel_o), .busy_o(busy_o));

// file: test/iala_mem_model.sv
// Model of the core memory window that feeds operand fetches.
// Assumes the bench mirrors here every core memory word it loads into the design.
`timescale 1ns/100ps
module iala_mem_model (
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [3:0] idx_i,
   input wire logic [31:0] wdat_i,
   output logic [31:0] rdat_o
);
   logic [31:0] mem [16];
   // Words are kept as written, so expectations never read the design.
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[idx_i] <= wdat_i;
      end
   end
   assign rdat_o = mem[idx_i];
endmodule

// file: test/tb_top.sv
// Self-checking bench for the indexed address and lane datapath.
// Assumes a 10 MHz clock and the register map of the design package.
`timescale 1ns/100ps
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, we = 1'b0, m_we = 1'b0, ack, odd, busy;
   logic [7:0] adr = 8'h00;
   logic [3:0] m_idx = 4'h0;
   logic [31:0] dat = 32'h0, rd, ea, m_rd, w, seed = 32'hf7e97469;
   int bad_count = 0, compares = 0;
   logic [31:0] expq [$];
   always #50 clk_i = ~clk_i;
   iala_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .prog_addr_o(ea),
      .odd_word_sel_o(odd), .busy_o(busy));
   iala_mem_model u_mem (.clk_i(clk_i), .we_i(m_we), .idx_i(m_idx),
      .wdat_i(dat), .rdat_o(m_rd));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic iala_pkg::iala_ctrl_s mk(input iala_pkg::iala_size_e s,
      input iala_pkg::iala_kind_e k, input logic [2:0] x,
      input logic [2:0] r, input logic f);
      return '{r, 1'b0, f, k, s, x};
   endfunction
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // One classic cycle; the idle cycle after it keeps requests apart.
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      cyc <= 1'b1;
      we <= wr;
      adr <= a;
      dat <= d;
      @(posedge clk_i);
      repeat (20) if (ack !== 1'b1) @(posedge clk_i);
      // A missing answer is a failure, not a silent pass.
      if (ack !== 1'b1) bad_count++;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic getm(input logic [3:0] i, output logic [31:0] v);
      m_idx <= i;
      @(posedge clk_i);
      v = m_rd;
   endtask
   // Starts one preparation run and waits, bounded, for its end.
   task automatic run(input iala_pkg::iala_ctrl_s c, input logic [31:0] r);
      bus(1'b1, iala_pkg::OFS_REF, r);
      bus(1'b1, iala_pkg::OFS_CTRL, {18'h0, c, 1'b1});
      repeat (40) if (busy !== 1'b0) @(posedge clk_i);
      if (busy !== 1'b0) bad_count++;
   endtask
   // Each read answer is paired with the oldest expected value.
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0) begin
         cmp(rd, expq.pop_front());
      end
   end
   // The span allows many times the expected run length.
   initial begin
      #2000000;
      bad_count++;
      complete_run();
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd_chk(iala_pkg::OFS_STATUS, 32'h0);
      rd_chk(8'hfc, 32'h0);
      for (int i = 1; i < 8; i++) bus(1'b1, 8'h40 + 8'(4 * i), 32'(i));
      bus(1'b1, 8'h58, 32'ha5);
      for (int i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         m_we <= 1'b1;
         m_idx <= 4'(i);
         bus(1'b1, 8'h80 + 8'(4 * i), seed);
      end
      m_we <= 1'b0;
      $display("setup done");
      for (int b = 0; b < 4; b++) begin
         run(mk(iala_pkg::SZ_BYTE, iala_pkg::KD_LOAD, 3'(b), 3'h0, 1'b0), 4);
         getm(4'h4, w);
         rd_chk(iala_pkg::OFS_RESULT, (w >> (8 * (3 - b))) & 32'hff);
         cmp(ea, 32'h4);
      end
      for (int h = 0; h < 2; h++) begin
         run(mk(iala_pkg::SZ_HALF, iala_pkg::KD_LOAD, 3'(2 - h), 3'h0, 1'b0),
            4);
         getm(4'(5 - h), w);
         w = h ? w : w >> 16;
         rd_chk(iala_pkg::OFS_RESULT, {{16{w[15]}}, w[15:0]});
      end
      $display("lane loads done");
      run(mk(iala_pkg::SZ_WORD, iala_pkg::KD_LOAD, 3'h3, 3'h0, 1'b0), 4);
      cmp(ea, 32'h7);
      getm(4'h7, w);
      rd_chk(iala_pkg::OFS_RESULT, w);
      run(mk(iala_pkg::SZ_DOUBLE, iala_pkg::KD_LOAD, 3'h3, 3'h0, 1'b0), 5);
      cmp(ea, 32'ha);
      cmp({31'h0, odd}, 32'h1);
      rd_chk(iala_pkg::OFS_STATUS, 32'h602);
      run(mk(iala_pkg::SZ_DOUBLE, iala_pkg::KD_LOAD, 3'h3, 3'h0, 1'b1), 5);
      cmp({31'h0, odd}, 32'h0);
      $display("word and double done");
      run(mk(iala_pkg::SZ_IMMED, iala_pkg::KD_LOAD, 3'h0, 3'h0, 1'b0),
         32'h00080005);
      rd_chk(iala_pkg::OFS_RESULT, 32'hfff80005);
      run(mk(iala_pkg::SZ_BYTE, iala_pkg::KD_STORE, 3'h1, 3'h6, 1'b0), 4);
      rd_chk(iala_pkg::OFS_RESULT, 32'h00a50000);
      run(mk(iala_pkg::SZ_HALF, iala_pkg::KD_STORE, 3'h2, 3'h6, 1'b0), 4);
      rd_chk(iala_pkg::OFS_RESULT, 32'h00a50000);
      // Modify-and-test on byte 2: shift down, step, shift back up.
      run(mk(iala_pkg::SZ_BYTE, iala_pkg::KD_MODTEST, 3'h2, 3'h0, 1'b0), 4);
      getm(4'h4, w);
      rd_chk(iala_pkg::OFS_RESULT, ((w >> 8) + 32'h1) << 8);
      run(mk(iala_pkg::SZ_SHIFT, iala_pkg::KD_LOAD, 3'h3, 3'h0, 1'b0), 5);
      rd_chk(iala_pkg::OFS_SHIFT, 32'h88);
      $display("pad store shift done");
      complete_run();
   end
endmodule
